// [logic/ira_pkg.sv]
// Purpose: Shared constants and types for the I2C register access slave
// Assumes: System clock of 50 MHz; SCL and SDA are sampled, never clocked
// Notes: Filter lengths are counts of system cycles derived from times

package ira_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 50;
  // Spike width rejected in the normal (up to 1 MHz) filter setting
  localparam int FILT_STD_NS = 40;
  // Spike width rejected in the high-speed filter setting
  localparam int FILT_HS_NS = 20;
  localparam int FILT_STD_CYC = (FILT_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_HS_CYC = (FILT_HS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] FILT_STD_LEN = 3'(FILT_STD_CYC);
  localparam logic [2:0] FILT_HS_LEN = 3'(FILT_HS_CYC);

  // ==========================================================================
  // Bus addressing, 8-bit address byte form
  localparam logic [7:0] ADDR_WR_BYTE = 8'hD2;
  localparam logic [7:0] ADDR_RD_BYTE = 8'hD3;
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ==========================================================================
  // Bit counting
  localparam logic [3:0] RX_LAST = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;

  // ==========================================================================
  // Write buffer shape: register pointer and data byte per word
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Protocol engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_RACK = 5'h10
  } ira_state_t;

  // Meaning of the byte being received
  typedef enum logic [2:0] {
    BK_ADDR = 3'h1,
    BK_PTR = 3'h2,
    BK_DATA = 3'h4
  } ira_kind_t;

endpackage

// [logic/ira_filter.sv]
// Purpose: Synchroniser and glitch filter for one bus line
// Assumes: Pin idles high; i_len is at least one
// Notes: Output follows the pin once it has held a new level i_len cycles

`timescale 1ns/100ps

module ira_filter (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Line and filter length
  input wire logic i_pin,
  input wire logic [2:0] i_len,
  // Filtered level
  output logic o_level
);

  logic sync_a;
  logic sync_b;
  logic [2:0] cnt;

  // ==========================================================================
  // Two-flop synchroniser; sync_a feeds sync_b only
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end
    else
    begin
      sync_a <= i_pin;
      sync_b <= sync_a;
    end
  end

  // Stability counter; any bounce back restarts it, so spikes shorter than i_len cycles never pass
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cnt <= 3'h0;
      o_level <= 1'b1;
    end
    else if (sync_b == o_level)
    begin
      cnt <= 3'h0;
    end
    else if ((cnt + 3'h1) >= i_len)
    begin
      cnt <= 3'h0;
      o_level <= sync_b;
    end
    else
    begin
      cnt <= cnt + 3'h1;
    end
  end

endmodule

// [logic/ira_fifo.sv]
// Purpose: Small synchronous FIFO with a registered output stage
// Assumes: DEPTH is a power of two
// Notes: Head word sits in o_out_data; popping refills it one cycle later

`timescale 1ns/100ps

module ira_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic do_push;
  logic do_pop;

  // ==========================================================================
  // Full when the store holds DEPTH words, not counting the output stage
  assign o_in_ready = (cnt != (AW + 1)'(DEPTH));
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = (cnt != '0) && (!o_out_valid || i_out_ready);

  // Storage
  always_ff @(posedge i_clock)
  begin
    if (do_push)
    begin
      mem[wp] <= i_in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wp <= wp + 1'b1;
      end
      if (do_pop)
      begin
        rp <= rp + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt <= cnt + (AW + 1)'(1);
      end
      else if (do_pop && !do_push)
      begin
        cnt <= cnt - (AW + 1)'(1);
      end
    end
  end

  // Output stage holds until the drain takes it
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end
    else if (do_pop)
    begin
      o_out_valid <= 1'b1;
      o_out_data <= mem[rp];
    end
    else if (i_out_ready)
    begin
      o_out_valid <= 1'b0;
    end
  end

endmodule

// [logic/ira_reg_access.sv]
// Purpose: I2C target engine giving a bus master access to a register bank
// Assumes: Register bank on i_clock; i_rd_data follows o_rd_addr at once
// Notes: Writes leave through a FIFO; a full FIFO makes data bytes NACK
//
// Summary of operation
// (R01) START, 7-bit address, write bit; matching address is acknowledged low.
// (R02) After write address the master sends a pointer byte, acknowledged.
// (R03) Data byte acknowledged and committed at that acknowledge's SCL rise.
// (R04) Sequential write: further bytes go to consecutive registers, all acked; here a full FIFO makes data bytes NACK.
// (R05) The last data byte of a sequential write is acknowledged too; here it is NACKed if the FIFO is full.
// (R06) Pair mode: pointer then data repeat freely within one addressing.
// (R07) Pair writes are accepted until the master sends STOP; here a full FIFO makes data bytes NACK.
// (R08) Pair mode: pending data byte committed at the STOP's SDA rise.
// (R09) Read: pointer write, repeated START, address with read bit, acked.
// (R10) After read address ack, shift out pointed register, MSB first.
// (R11) Master NACK after a data byte: device releases SDA and stops.
// (R12) Master ACK after a data byte: send the next consecutive register.
// (R13) Master ends a sequential read with a NACK.
// (R14) STOP returns input filters to the normal up-to-1MHz setting.
// (R15) Repeated START leaves the filter setting unchanged.
// (R16) Single writes follow the SMBus Write Byte format.
// (R17) Single reads follow the SMBus Read Byte format.
// (R18) Address bytes D2 write and D3 read are answered.
// (R19) SCL is never held low.
// (R20) General call address is not acknowledged.
// (R21) After STOP or a foreign address, SCL is ignored until START.
// (R22) Lines pass synchronisers and glitch filters before any decoding.
// (R23) An input selects sequential or register-data pair interpretation.

`timescale 1ns/100ps

module ira_reg_access (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Bus pins, open drain
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Configuration and filter mode
  input wire logic i_pair_mode,
  input wire logic i_hs_enter,
  output logic o_filter_hs,
  // Register write stream
  output logic o_wr_valid,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  input wire logic i_wr_ready,
  // Register read port
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);

  // Address byte check, used by the engine's acknowledge decision only
  function automatic logic addr_match(input logic [7:0] b);
    addr_match = (b != ira_pkg::GEN_CALL) &&
                 ((b == ira_pkg::ADDR_WR_BYTE) ||
                  (b == ira_pkg::ADDR_RD_BYTE));
  endfunction

  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic filter_hs;
  logic [2:0] filt_len;
  ira_pkg::ira_state_t state;
  ira_pkg::ira_kind_t kind;
  logic [3:0] bitcnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] ptr;
  logic more;
  logic give_ack;
  logic byte_done;
  logic commit_c;
  logic load_c;
  logic pend_valid;
  logic [7:0] pend_addr;
  logic [7:0] pend_data;
  logic push_valid;
  logic [15:0] push_word;
  logic fifo_ready;
  logic [15:0] out_word;

  // ==========================================================================
  // Line conditioning
  assign filt_len = filter_hs ? ira_pkg::FILT_HS_LEN : ira_pkg::FILT_STD_LEN;

  // Both lines see the same delay, so START and STOP keep their order
  ira_filter u_scl_filt ( // R22
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_scl),
    .i_len(filt_len),
    .o_level(scl_f)
  );

  ira_filter u_sda_filt ( // R22
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_sda),
    .i_len(filt_len),
    .o_level(sda_f)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Edges and bus conditions from filtered samples
  assign scl_rise = scl_f && !scl_q; // R22
  assign scl_fall = !scl_f && scl_q; // R22
  assign start_c = scl_f && scl_q && sda_q && !sda_f; // R22
  assign stop_c = scl_f && scl_q && !sda_q && sda_f; // R22

  // ==========================================================================
  // Filter mode: high-speed entry comes from outside, STOP always ends it
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      filter_hs <= 1'b0;
    end
    else if (stop_c)
    begin
      filter_hs <= 1'b0; // R14
    end
    else if (i_hs_enter)
    begin
      filter_hs <= 1'b1; // R15
    end
  end

  // ==========================================================================
  // Acknowledge decision for the byte just received
  assign byte_done = scl_fall && (state == ira_pkg::ST_RX) &&
                     (bitcnt == ira_pkg::RX_LAST);

  always_comb
  begin
    give_ack = 1'b0;
    unique case (kind)
      ira_pkg::BK_ADDR: give_ack = addr_match(rx_sh); // R01 R09 R18 R20
      ira_pkg::BK_PTR: give_ack = 1'b1; // R02
      ira_pkg::BK_DATA: give_ack = fifo_ready; // R04 R05 R07
    endcase
  end

  // ==========================================================================
  // Protocol engine; START and STOP win over any bit activity
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state <= ira_pkg::ST_IDLE;
      kind <= ira_pkg::BK_ADDR;
      bitcnt <= 4'h0;
      rx_sh <= 8'h00;
      more <= 1'b0;
    end
    else if (start_c)
    begin
      state <= ira_pkg::ST_RX;
      kind <= ira_pkg::BK_ADDR;
      bitcnt <= 4'h0;
    end
    else if (stop_c)
    begin
      state <= ira_pkg::ST_IDLE; // R21
    end
    else
    begin
      unique case (state)
        ira_pkg::ST_IDLE:
        begin
          bitcnt <= 4'h0; // R21
        end
        ira_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            rx_sh <= {rx_sh[6:0], sda_f};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (byte_done)
          begin
            state <= give_ack ? ira_pkg::ST_ACK : ira_pkg::ST_IDLE; // R21
          end
        end
        ira_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if ((kind == ira_pkg::BK_ADDR) && rx_sh[0])
            begin
              state <= ira_pkg::ST_TX; // R09 R17
            end
            else
            begin
              state <= ira_pkg::ST_RX;
              unique case (kind)
                ira_pkg::BK_ADDR: kind <= ira_pkg::BK_PTR; // R02 R16
                ira_pkg::BK_PTR: kind <= ira_pkg::BK_DATA;
                ira_pkg::BK_DATA: kind <= i_pair_mode ? // R23
                  ira_pkg::BK_PTR : ira_pkg::BK_DATA; // R04 R06
              endcase
            end
          end
        end
        ira_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (bitcnt == ira_pkg::TX_LAST)
            begin
              state <= ira_pkg::ST_RACK;
              bitcnt <= 4'h0;
            end
            else
            begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        ira_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            more <= !sda_f; // R12
          end
          else if (scl_fall)
          begin
            state <= more ? ira_pkg::ST_TX : ira_pkg::ST_IDLE; // R11 R13
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Transmit loading and SDA drive; SDA only moves while SCL is low
  assign load_c = scl_fall &&
                  (((state == ira_pkg::ST_ACK) &&
                    (kind == ira_pkg::BK_ADDR) && rx_sh[0]) ||
                   ((state == ira_pkg::ST_RACK) && more));

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_sda_oe_n <= 1'b1;
      tx_sh <= 8'hFF;
    end
    else if (start_c || stop_c)
    begin
      o_sda_oe_n <= 1'b1;
    end
    else if (load_c)
    begin
      o_sda_oe_n <= i_rd_data[7]; // R10 R12
      tx_sh <= {i_rd_data[6:0], 1'b1};
    end
    else if (byte_done)
    begin
      o_sda_oe_n <= !give_ack; // R01 R02 R03 R05 R20
    end
    else if (scl_fall && (state == ira_pkg::ST_ACK))
    begin
      o_sda_oe_n <= 1'b1;
    end
    else if (scl_fall && (state == ira_pkg::ST_TX))
    begin
      // After bit 0 the line is let go for the master's answer
      o_sda_oe_n <= (bitcnt == ira_pkg::TX_LAST) ? 1'b1 : tx_sh[7]; // R10
      tx_sh <= {tx_sh[6:0], 1'b1};
    end
  end

  // Data pin is only ever pulled low; SCL is never driven at all
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_sda <= 1'b0;
      o_scl <= 1'b0;
      o_scl_oe_n <= 1'b1;
    end
    else
    begin
      o_sda <= 1'b0;
      o_scl <= 1'b0;
      o_scl_oe_n <= 1'b1; // R19
    end
  end

  // ==========================================================================
  // Register pointer: loaded by the pointer byte, advanced per byte read or written outside pair mode
  assign commit_c = scl_rise && (state == ira_pkg::ST_ACK) &&
                    (kind == ira_pkg::BK_DATA);

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ptr <= ira_pkg::PTR_RESET;
    end
    else if (scl_rise && (state == ira_pkg::ST_ACK) &&
             (kind == ira_pkg::BK_PTR))
    begin
      ptr <= rx_sh; // R02
    end
    else if (commit_c && !i_pair_mode)
    begin
      ptr <= ptr + 8'h01; // R04
    end
    else if (load_c)
    begin
      ptr <= ptr + 8'h01; // R12
    end
  end

  assign o_rd_addr = ptr;

  // ==========================================================================
  // Pair mode holds the last data byte until the next one, a START or a STOP
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pend_valid <= 1'b0;
      pend_addr <= 8'h00;
      pend_data <= 8'h00;
    end
    else if (start_c || stop_c)
    begin
      pend_valid <= 1'b0;
    end
    else if (commit_c && i_pair_mode)
    begin
      pend_valid <= 1'b1; // R06
      pend_addr <= ptr;
      pend_data <= rx_sh;
    end
  end

  // Write commit selection
  always_comb
  begin
    push_valid = 1'b0;
    push_word = {ptr, rx_sh};
    if ((start_c || stop_c) && pend_valid)
    begin
      push_valid = 1'b1; // R08
      push_word = {pend_addr, pend_data};
    end
    else if (commit_c && !i_pair_mode)
    begin
      push_valid = 1'b1; // R03 R04
    end
    else if (commit_c && pend_valid)
    begin
      push_valid = 1'b1; // R06 R07
      push_word = {pend_addr, pend_data};
    end
  end

  // Bus cannot be stretched, so the buffer absorbs a slow register bank
  ira_fifo #(
    .WIDTH(ira_pkg::FIFO_WIDTH),
    .DEPTH(ira_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_valid(push_valid),
    .i_in_data(push_word),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_wr_valid),
    .o_out_data(out_word),
    .i_out_ready(i_wr_ready)
  );

  assign o_wr_addr = out_word[15:8];
  assign o_wr_data = out_word[7:0];
  assign o_filter_hs = filter_hs;

  // ==========================================================================
  // Checks
  property p_gencall;
    @(posedge i_clock) disable iff (i_rst)
    (byte_done && (kind == ira_pkg::BK_ADDR) && (rx_sh == ira_pkg::GEN_CALL))
    |=> o_sda_oe_n [*2];
  endproperty
  a_gencall: assert property (p_gencall) // R20
    else $error("general call was acknowledged");

  property p_addr_ack;
    @(posedge i_clock) disable iff (i_rst)
    (byte_done && (kind == ira_pkg::BK_ADDR) &&
     (rx_sh[7:1] == ira_pkg::ADDR_WR_BYTE[7:1]))
    |=> !o_sda_oe_n && (state == ira_pkg::ST_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) // R18
    else $error("own address not acknowledged");

  property p_stop_filter;
    @(posedge i_clock) disable iff (i_rst)
    stop_c |=> !o_filter_hs && (state == ira_pkg::ST_IDLE);
  endproperty
  a_stop_filter: assert property (p_stop_filter) // R14
    else $error("filter mode not reset by stop");

  property p_sr_keep;
    @(posedge i_clock) disable iff (i_rst)
    (start_c && !i_hs_enter) |=> $stable(o_filter_hs);
  endproperty
  a_sr_keep: assert property (p_sr_keep) // R15
    else $error("filter mode changed by start");

  property p_scl_free;
    @(posedge i_clock) disable iff (i_rst)
    ##1 (o_scl_oe_n && !o_scl);
  endproperty
  a_scl_free: assert property (p_scl_free) // R19
    else $error("scl driven");

  property p_seq_commit;
    @(posedge i_clock) disable iff (i_rst)
    (commit_c && !i_pair_mode && !start_c && !stop_c)
    |-> push_valid && (push_word == {ptr, rx_sh}) ##1 ($past(ptr) + 8'h01 == ptr);
  endproperty
  a_seq_commit: assert property (p_seq_commit) // R03
    else $error("sequential byte not committed");

  property p_pair_stop;
    @(posedge i_clock) disable iff (i_rst)
    (stop_c && pend_valid)
    |-> push_valid && (push_word == {pend_addr, pend_data}) ##1 !pend_valid;
  endproperty
  a_pair_stop: assert property (p_pair_stop) // R08
    else $error("pending pair byte lost at stop");

  property p_idle_quiet;
    @(posedge i_clock) disable iff (i_rst)
    ((state == ira_pkg::ST_IDLE) && !start_c)
    |=> (state == ira_pkg::ST_IDLE) && o_sda_oe_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // R21
    else $error("engine left idle without start");

  property p_tx_msb;
    @(posedge i_clock) disable iff (i_rst)
    (load_c && !start_c && !stop_c)
    |=> (o_sda_oe_n == $past(i_rd_data[7])) && (state == ira_pkg::ST_TX);
  endproperty
  a_tx_msb: assert property (p_tx_msb) // R10
    else $error("read byte msb not driven first");

  property p_nack_end;
    @(posedge i_clock) disable iff (i_rst)
    ((state == ira_pkg::ST_RACK) && scl_fall && !more && !start_c && !stop_c)
    |=> o_sda_oe_n && (state == ira_pkg::ST_IDLE);
  endproperty
  a_nack_end: assert property (p_nack_end) // R11
    else $error("device kept sending after nack");

endmodule

// [bench/ira_master.sv]
// Purpose: Behavioural I2C bus master driving the target's bus pins
// Assumes: Open-drain lines with pull-ups; SCL period of 160 ns
// Notes: SCL stands high between frames; sample just before SCL falls

`timescale 1ns/100ps

module ira_master (
  // Resolved data line
  input wire logic i_line_sda,
  // Released (1) or pulled low (0)
  output logic o_scl,
  output logic o_sda
);
  // ==========================================================================
  // Bus idle until a task runs
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // START, or repeated START when SCL is low; SCL rises late so the
  // target has let go of its acknowledge before SDA is seen with SCL high
  task automatic start();
    #40 o_sda = 1'b1;
    #80 o_scl = 1'b1;
    #80 o_sda = 1'b0;
    #80 o_scl = 1'b0;
  endtask

  // STOP leaves both lines released, clock still
  task automatic stop();
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #80 o_sda = 1'b1;
    #160;
  endtask

  // One SCL pulse: long low, short high; the target answers about 100 ns
  // after SCL falls, so a square clock would move SDA while SCL is high
  task automatic bit_io(input logic b, output logic s);
    #40 o_sda = b;
    #80 o_scl = 1'b1;
    #39 s = i_line_sda;
    #1 o_scl = 1'b0;
  endtask

  // Eight bits MSB first plus acknowledge slot; d of FF reads
  task automatic byte_io(input logic [7:0] d, input logic ack_drv,
                         output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r[i]);
    end
    bit_io(ack_drv, ack);
  endtask
endmodule

// [bench/test_ira_reg_access.sv]
// Purpose: Self-checking bench for the I2C register access target
// Assumes: Master model on the pins, behavioural register bank behind
// Notes: Bank contents follow a fixed pattern of the register address

`timescale 1ns/100ps

module test_ira_reg_access;
  // ==========================================================================
  // Signals
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic pair = 1'b0;
  logic hs = 1'b0;
  logic ready = 1'b0;
  logic scl, sda_oe_n, sda_v, scl_oe_n, m_scl, m_sda, valid, hs_on;
  logic [7:0] wa, wd, ra, r;
  logic k;
  logic [15:0] got[$];
  int num_errors = 0;
  int checks_done = 0;
  wire sda_line = m_sda & (sda_oe_n | sda_v);
  wire scl_line = m_scl & (scl_oe_n | scl);

  initial
  begin
    forever #10 i_clock = ~i_clock;
  end

  ira_reg_access dut (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl_line),
    .o_scl(scl), .o_scl_oe_n(scl_oe_n), .i_sda(sda_line), .o_sda(sda_v),
    .o_sda_oe_n(sda_oe_n), .i_pair_mode(pair), .i_hs_enter(hs),
    .o_filter_hs(hs_on), .o_wr_valid(valid), .o_wr_addr(wa),
    .o_wr_data(wd), .i_wr_ready(ready), .o_rd_addr(ra),
    .i_rd_data(ra ^ 8'h5A));
  ira_master m (.i_line_sda(sda_line), .o_scl(m_scl), .o_sda(m_sda));

  // Bank logs every word taken from the write stream
  always @(posedge i_clock)
  begin
    if (valid === 1'b1 && ready === 1'b1)
      got.push_back({wa, wd});
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (e !== g)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // Bounded wait for the bank to hold n words
  task automatic wait_words(input int n);
    int t;
    t = 0;
    while (got.size() < n && t < 400)
    begin
      tick(1);
      t++;
    end
    if (t == 400)
      chk("drain_timeout", 16'h0, 16'h1);
  endtask

  // ==========================================================================
  // Sequential write against a stalled bank until the buffer refuses
  task automatic t_write_fill();
    m.start();
    m.byte_io(8'hD2, 1'b1, r, k);
    chk("addr_ack", 16'h0, 16'(k));
    m.byte_io(8'hF8, 1'b1, r, k);
    chk("ptr_ack", 16'h0, 16'(k));
    // Sixteen stored words plus the output stage are taken, then refused
    for (int i = 0; i < 18; i++)
    begin
      m.byte_io(8'(i * 7), 1'b1, r, k);
      chk("data_ack", 16'(i == 17), 16'(k));
    end
    m.stop();
    ready = 1'b1;
    wait_words(17);
    for (int i = 0; i < 17; i++)
      chk("word", {8'(8'hF8 + i), 8'(i * 7)}, got[i]);
    chk("count", 16'd17, 16'(got.size()));
    got.delete();
  endtask

  // Single write, then single read of the same register
  task automatic t_single();
    m.start();
    m.byte_io(8'hD2, 1'b1, r, k);
    m.byte_io(8'h40, 1'b1, r, k);
    m.byte_io(8'h9C, 1'b1, r, k);
    chk("wr_byte_ack", 16'h0, 16'(k));
    m.stop();
    wait_words(1);
    chk("wr_byte", 16'h409C, got[0]);
    got.delete();
    m.start();
    m.byte_io(8'hD2, 1'b1, r, k);
    m.byte_io(8'h40, 1'b1, r, k);
    m.start();
    m.byte_io(8'hD3, 1'b1, r, k);
    chk("rd1_addr_ack", 16'h0, 16'(k));
    m.byte_io(8'hFF, 1'b1, r, k);
    chk("rd1_byte", 16'(8'h40 ^ 8'h5A), 16'(r));
    tick(8);
    chk("rd1_released", 16'h1, 16'(sda_oe_n));
    m.stop();
  endtask

  // Register-data pairs; last one lands only at STOP
  task automatic t_pairs();
    pair = 1'b1;
    m.start();
    m.byte_io(8'hD2, 1'b1, r, k);
    m.byte_io(8'h33, 1'b1, r, k);
    m.byte_io(8'hC1, 1'b1, r, k);
    m.byte_io(8'h05, 1'b1, r, k);
    m.byte_io(8'h7E, 1'b1, r, k);
    chk("pair_ack", 16'h0, 16'(k));
    tick(10);
    chk("pair_early", 16'd1, 16'(got.size()));
    m.stop();
    wait_words(2);
    chk("pair0", 16'h33C1, got[0]);
    chk("pair1", 16'h057E, got[1]);
    got.delete();
    pair = 1'b0;
  endtask

  // Sequential read across a repeated START, filter mode tracked
  task automatic t_read();
    hs = 1'b1;
    tick(1);
    hs = 1'b0;
    m.start();
    m.byte_io(8'hD2, 1'b1, r, k);
    m.byte_io(8'hFE, 1'b1, r, k);
    m.start();
    m.byte_io(8'hD3, 1'b1, r, k);
    chk("rd_addr_ack", 16'h0, 16'(k));
    chk("hs_kept", 16'h1, 16'(hs_on));
    for (int i = 0; i < 3; i++)
    begin
      m.byte_io(8'hFF, 1'(i == 2), r, k);
      chk("rd_byte", 16'(8'(8'hFE + i) ^ 8'h5A), 16'(r));
    end
    tick(8);
    chk("released", 16'h1, 16'(sda_oe_n));
    m.stop();
    tick(4);
    chk("hs_clear", 16'h0, 16'(hs_on));
  endtask

  // General call and a foreign address go unanswered
  task automatic t_refuse();
    m.start();
    m.byte_io(8'h00, 1'b1, r, k);
    chk("gen_call", 16'h1, 16'(k));
    m.byte_io(8'hD2, 1'b1, r, k);
    chk("ignored", 16'h1, 16'(k));
    m.stop();
    m.start();
    m.byte_io(8'hD4, 1'b1, r, k);
    chk("foreign", 16'h1, 16'(k));
    m.stop();
    chk("no_words", 16'h0, 16'(got.size()));
    chk("scl_free", 16'h1, 16'(scl_oe_n));
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    tick(2);
    i_rst = 1'b0;
    tick(4);
    t_write_fill();
    t_pairs();
    t_single();
    t_read();
    t_refuse();
    finish_test();
  end
endmodule
